// File: inc/fbsr_pkg.sv
// shared constants and types for the four-bit shift register
package fbsr_pkg;

    // register geometry
    localparam int FBSR_WIDTH = 4;
    localparam int FBSR_SER_STAGE = 0;
    localparam int FBSR_TOP_STAGE = FBSR_WIDTH - 1;
    localparam logic [FBSR_WIDTH-1:0] FBSR_STAGES_RST = 4'h0;

    // mode control levels
    localparam logic FBSR_MODE_PAR = 1'b1;
    localparam logic FBSR_MODE_SER = 1'b0;

    // fifo in the captured-word path
    localparam int FBSR_FIFO_DEPTH = 16;

    // timing, in ns and in mclk cycles
    localparam int FBSR_CLK_PERIOD_NS = 100;
    localparam int FBSR_PAR_SETUP_NS = 30;
    localparam int FBSR_SER_SETUP_NS = 20;
    localparam int FBSR_PAR_SETUP_RAW =
        (FBSR_PAR_SETUP_NS + FBSR_CLK_PERIOD_NS - 1) / FBSR_CLK_PERIOD_NS;
    localparam int FBSR_SER_SETUP_RAW =
        (FBSR_SER_SETUP_NS + FBSR_CLK_PERIOD_NS - 1) / FBSR_CLK_PERIOD_NS;
    localparam int FBSR_PAR_SETUP_CYC =
        (FBSR_PAR_SETUP_RAW < 1) ? 1 : FBSR_PAR_SETUP_RAW;
    localparam int FBSR_SER_SETUP_CYC =
        (FBSR_SER_SETUP_RAW < 1) ? 1 : FBSR_SER_SETUP_RAW;

    // mode age counter
    localparam int FBSR_AGE_W = 8;
    localparam logic [FBSR_AGE_W-1:0] FBSR_AGE_MAX = 8'hff;
    localparam logic [FBSR_AGE_W-1:0] FBSR_AGE_RST = 8'h00;

    // transfer chosen in a cycle
    typedef enum logic [1:0] {
        FBSR_OP_HOLD,
        FBSR_OP_LOAD,
        FBSR_OP_SHIFT
    } fbsr_op_t;

endpackage

// File: hdl/fbsr_fifo.sv
// fifo for captured register words
`timescale 1ns/100ps
module fbsr_fifo
    import fbsr_pkg::*;
#(
    parameter int WIDTH = FBSR_WIDTH,
    parameter int DEPTH = FBSR_FIFO_DEPTH
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // fill side
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    // drain side
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wr;
        logic [PW-1:0] rd;
        logic [CW-1:0] count;
    } fbsr_fifo_state_t;

    fbsr_fifo_state_t s_q;
    fbsr_fifo_state_t s_d;
    logic push;
    logic pop;

    // pointer step with wrap
    function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
        step = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    assign in_ready_out = (s_q.count != CW'(DEPTH));
    assign out_valid_out = (s_q.count != '0);
    assign out_data_out = s_q.mem[s_q.rd];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wr] = in_data_in;
            s_d.wr = step(s_q.wr);
        end
        if (pop) begin
            s_d.rd = step(s_q.rd);
        end
        case ({push, pop})
            2'b10: s_d.count = s_q.count + 1'b1;
            2'b01: s_d.count = s_q.count - 1'b1;
            default: s_d.count = s_q.count;
        endcase
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule // fbsr_fifo

// File: hdl/fbsr_core.sv
// four-bit shift register with parallel load and serial shift
//
// Function
// [R1] mode high: strobe pulse loads all four parallel inputs into stages.
// [R2] mode low: each clock pulse shifts the register contents once.
// [R3] transfer happens on the falling edge of the active clock or strobe.
// [R4] surrounding logic keeps clock low while mode goes low to high.
// [R5] surrounding logic keeps strobe low while mode goes high to low.
// [R6] serial shift: stage 0 takes par_in bit 0, each stage feeds next.
// [R7] shift left by external wiring, mode high, strobe pulses.
// [R8] stages hold and show their value when no active falling edge.
`timescale 1ns/100ps
module fbsr_core
    import fbsr_pkg::*;
#(
    parameter int WIDTH = FBSR_WIDTH,
    parameter int DEPTH = FBSR_FIFO_DEPTH
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,

    // control pins
    input wire logic mode_in,
    input wire logic strobe_in,
    input wire logic shift_clk_in,

    // data pins
    input wire logic [WIDTH-1:0] par_in,
    output logic [WIDTH-1:0] q_out,

    // stream of captured words
    output logic word_valid_out,
    input wire logic word_ready_in,
    output logic [WIDTH-1:0] word_out,
    output logic load_ready_out,

    // status
    input wire logic err_clear_in,
    output logic order_err_out,
    output logic setup_err_out,
    output logic overrun_out
);

    // pin samples, mode age, stages and sticky flags
    typedef struct packed {
        logic strobe;
        logic sclk;
        logic mode;
        logic [FBSR_AGE_W-1:0] mode_age;
        logic [WIDTH-1:0] stages;
        logic order_err;
        logic setup_err;
        logic overrun;
    } fbsr_state_t;

    fbsr_state_t s_q;
    fbsr_state_t s_d;

    // decoded edges and transfer
    fbsr_op_t op;
    logic fall_stb;
    logic fall_clk;
    logic rise_stb;
    logic rise_clk;
    logic mode_up;
    logic mode_down;
    logic push;
    logic fifo_ready;

    // level went from high to low
    function automatic logic fell(input logic was, input logic now);
        fell = was && !now;
    endfunction

    // level went from low to high
    function automatic logic rose(input logic was, input logic now);
        rose = !was && now;
    endfunction

    // true when mode has stood for fewer cycles than needed
    function automatic logic mode_age_short(
        input logic [FBSR_AGE_W-1:0] age,
        input logic changed,
        input int need
    );
        logic [FBSR_AGE_W:0] held;
        held = {1'b0, age} + 1'b1;
        mode_age_short = changed || (held < (FBSR_AGE_W+1)'(need));
    endfunction

    // edge decode
    always_comb begin
        fall_stb = fell(s_q.strobe, strobe_in);
        fall_clk = fell(s_q.sclk, shift_clk_in);
        rise_stb = rose(s_q.strobe, strobe_in);
        rise_clk = rose(s_q.sclk, shift_clk_in);
        mode_up = rose(s_q.mode, mode_in);
        mode_down = fell(s_q.mode, mode_in);
    end

    // transfer selection
    always_comb begin
        op = FBSR_OP_HOLD;
        // a pulse on the idle input is ignored
        if (mode_in == FBSR_MODE_PAR) begin
            if (fall_stb) begin
                op = FBSR_OP_LOAD; // [R1] [R3] [R7]
            end
        end else begin
            if (fall_clk) begin
                op = FBSR_OP_SHIFT; // [R2] [R3]
            end
        end
    end

    // next state
    always_comb begin
        s_d = s_q;
        s_d.strobe = strobe_in;
        s_d.sclk = shift_clk_in;
        s_d.mode = mode_in;

        // age of the current mode level, saturating
        if (mode_in != s_q.mode) begin
            s_d.mode_age = FBSR_AGE_RST;
        end else if (s_q.mode_age != FBSR_AGE_MAX) begin
            s_d.mode_age = s_q.mode_age + 1'b1;
        end

        // stage update
        case (op)
            FBSR_OP_LOAD: begin
                s_d.stages = par_in; // [R1]
            end
            FBSR_OP_SHIFT: begin
                s_d.stages = {s_q.stages[WIDTH-2:0],
                    par_in[FBSR_SER_STAGE]}; // [R6]
            end
            FBSR_OP_HOLD: begin
                s_d.stages = s_q.stages; // [R8]
            end
            default: begin
                s_d.stages = s_q.stages;
            end
        endcase

        // sticky flags, clear first so a new event wins
        if (err_clear_in) begin
            s_d.order_err = 1'b0;
            s_d.setup_err = 1'b0;
            s_d.overrun = 1'b0;
        end

        // mode changed while the pulse input was high
        if (mode_up && (shift_clk_in || s_q.sclk)) begin
            s_d.order_err = 1'b1; // [R4]
        end
        if (mode_down && (strobe_in || s_q.strobe)) begin
            s_d.order_err = 1'b1; // [R5]
        end

        // pulse began before mode was settled long enough
        if (rise_stb && (mode_in == FBSR_MODE_PAR) &&
            (mode_age_short(s_q.mode_age, mode_up, FBSR_PAR_SETUP_CYC))) begin
            s_d.setup_err = 1'b1;
        end
        if (rise_clk && (mode_in == FBSR_MODE_SER) &&
            (mode_age_short(s_q.mode_age, mode_down,
                FBSR_SER_SETUP_CYC))) begin
            s_d.setup_err = 1'b1;
        end

        // captured word found the fifo full
        if (push && !fifo_ready) begin
            s_d.overrun = 1'b1;
        end
    end

    // state register; pin samples reset low so idle pins show no edge
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            s_q.strobe <= 1'b0;
            s_q.sclk <= 1'b0;
            s_q.mode <= FBSR_MODE_SER;
            s_q.mode_age <= FBSR_AGE_RST;
            s_q.stages <= FBSR_STAGES_RST;
            s_q.order_err <= 1'b0;
            s_q.setup_err <= 1'b0;
            s_q.overrun <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // every transfer offers the new word to the fifo
    assign push = (op != FBSR_OP_HOLD);

    // a full fifo drops the word but the stages still move
    fbsr_fifo #(
        .WIDTH(WIDTH),
        .DEPTH(DEPTH)
    ) fbsr_fifo_inst (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .in_valid_in(push),
        .in_ready_out(fifo_ready),
        .in_data_in(s_d.stages),
        .out_valid_out(word_valid_out),
        .out_ready_in(word_ready_in),
        .out_data_out(word_out)
    );

    // outputs
    assign q_out = s_q.stages; // [R8]
    assign load_ready_out = fifo_ready;
    assign order_err_out = s_q.order_err;
    assign setup_err_out = s_q.setup_err;
    assign overrun_out = s_q.overrun;

endmodule // fbsr_core

// File: tb/fbsr_core_monitor.sv
// port checker for the four-bit shift register
`timescale 1ns/100ps
module fbsr_core_monitor
    import fbsr_pkg::*;
#(
    parameter int WIDTH = FBSR_WIDTH,
    parameter int DEPTH = FBSR_FIFO_DEPTH
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // pins
    input wire logic mode_in,
    input wire logic strobe_in,
    input wire logic shift_clk_in,
    input wire logic [WIDTH-1:0] par_in,
    input wire logic [WIDTH-1:0] q_out,
    // stream and status
    input wire logic word_valid_out,
    input wire logic word_ready_in,
    input wire logic [WIDTH-1:0] word_out,
    input wire logic load_ready_out,
    input wire logic err_clear_in,
    input wire logic order_err_out,
    input wire logic setup_err_out,
    input wire logic overrun_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    logic stb_q, sck_q, mode_q, ld, sh;
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            stb_q <= 1'b0;
            sck_q <= 1'b0;
            mode_q <= 1'b0;
        end else begin
            stb_q <= strobe_in;
            sck_q <= shift_clk_in;
            mode_q <= mode_in;
        end
    end
    assign ld = mode_in == FBSR_MODE_PAR && stb_q && !strobe_in;
    assign sh = mode_in == FBSR_MODE_SER && sck_q && !shift_clk_in;
    property p_load; ld |=> q_out == $past(par_in); endproperty
    a_load: assert property (p_load)
        else $error("load not taken");
    property p_shift;
        sh |=> q_out == {$past(q_out[WIDTH-2:0]), $past(par_in[0])};
    endproperty
    a_shift: assert property (p_shift)
        else $error("shift wrong");
    property p_hold; !ld && !sh |=> $stable(q_out); endproperty
    a_hold: assert property (p_hold)
        else $error("stages moved");
    property p_push; (ld || sh) && load_ready_out |=> word_valid_out;
    endproperty
    a_push: assert property (p_push)
        else $error("word not pushed");
    property p_drop; (ld || sh) && !load_ready_out |=> overrun_out;
    endproperty
    a_drop: assert property (p_drop)
        else $error("overrun missed");
    property p_order; mode_in && !mode_q && shift_clk_in |=> order_err_out;
    endproperty
    a_order: assert property (p_order)
        else $error("order error missed");
    property p_space; !word_valid_out |-> load_ready_out; endproperty
    a_space: assert property (p_space)
        else $error("empty fifo not ready");
    property p_sticky; overrun_out && !err_clear_in |=> overrun_out;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("overrun flag lost");
    property p_stand;
        word_valid_out && !word_ready_in |=>
            word_valid_out ##0 $stable(word_out);
    endproperty
    a_stand: assert property (p_stand)
        else $error("word not held");
    property p_setup;
        shift_clk_in && !sck_q && !mode_in && mode_q |=> setup_err_out;
    endproperty
    a_setup: assert property (p_setup)
        else $error("setup error missed");
endmodule // fbsr_core_monitor
bind fbsr_core fbsr_core_monitor #(.WIDTH(WIDTH), .DEPTH(DEPTH))
    fbsr_core_monitor_inst (.mclk_in, .rst_in, .mode_in, .strobe_in,
    .shift_clk_in, .par_in, .q_out, .word_valid_out, .word_ready_in,
    .word_out, .load_ready_out, .err_clear_in, .order_err_out,
    .setup_err_out, .overrun_out);

// File: tb/fbsr_ctl_model.sv
// surrounding logic driving mode, strobe and shift clock
`timescale 1ns/100ps
module fbsr_ctl_model (
    // clock
    input wire logic mclk_in,
    // control pins
    output logic mode_out,
    output logic strobe_out,
    output logic sclk_out
);
    initial begin
        mode_out = 1'b0;
        strobe_out = 1'b0;
        sclk_out = 1'b0;
    end
    // one transfer; bad changes mode to par with the clock high
    task automatic xfer(input logic par, input logic bad);
        if (mode_out !== par) begin
            @(posedge mclk_in);
            #10;
            sclk_out = bad;
            mode_out = par;
            @(posedge mclk_in);
            #10;
            sclk_out = 1'b0;
        end
        @(posedge mclk_in);
        #10;
        strobe_out = par;
        sclk_out = !par;
        @(posedge mclk_in);
        #10;
        strobe_out = 1'b0;
        sclk_out = 1'b0;
    endtask
    // mode falls as the clock rises in one sample: setup too short
    task automatic rush();
        @(posedge mclk_in);
        #10;
        mode_out = 1'b0;
        sclk_out = 1'b1;
        @(posedge mclk_in);
        #10;
        sclk_out = 1'b0;
    endtask
endmodule // fbsr_ctl_model

// File: tb/fbsr_core_bench.sv
// self-checking bench for the four-bit shift register
`timescale 1ns/100ps
module fbsr_core_bench;
    import fbsr_pkg::*;
    logic mclk_in = 1'b0, rst_in = 1'b1, rdy = 1'b0, clr = 1'b0;
    logic mode, strobe, sclk, valid, ldy, oerr, serr, ovr;
    logic [3:0] par = 4'h0, exp_q = 4'h0, q, word;
    logic [31:0] r;
    int err_total = 0, checked = 0, seed = 32'he0dd, i, k;
    logic [3:0] fifo_q[$];
    initial forever #50 mclk_in = ~mclk_in;
    initial begin
        #1000000;
        err_total++;
        summarize;
    end
    fbsr_ctl_model fbsr_ctl_model_inst (.mclk_in(mclk_in),
        .mode_out(mode), .strobe_out(strobe), .sclk_out(sclk));
    fbsr_core fbsr_core_inst (.mclk_in(mclk_in), .rst_in(rst_in),
        .mode_in(mode), .strobe_in(strobe), .shift_clk_in(sclk),
        .par_in(par), .q_out(q), .word_valid_out(valid),
        .word_ready_in(rdy), .word_out(word), .load_ready_out(ldy),
        .err_clear_in(clr), .order_err_out(oerr), .setup_err_out(serr),
        .overrun_out(ovr));
    task automatic chk(input string n, input logic [3:0] e,
                       input logic [3:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    function automatic logic [3:0] next_q(input logic p, input logic [3:0] d);
        return p ? d : {exp_q[2:0], d[0]};
    endfunction
    task automatic step(input logic p, input logic [3:0] d, input logic bad);
        par = d;
        fbsr_ctl_model_inst.xfer(p, bad);
        exp_q = next_q(p, d);
        if (fifo_q.size() < 16) fifo_q.push_back(exp_q);
        @(posedge mclk_in);
        #10;
        chk("q_out", exp_q, q);
    endtask
    task automatic drain;
        rdy = 1'b1;
        for (k = 0; k < 40 && valid !== 1'b0; k++) begin
            @(posedge mclk_in);
            #10;
        end
        if (k == 40) begin
            err_total++;
            summarize;
        end
        chk("left", 4'h0, 4'(fifo_q.size()));
    endtask
    always @(posedge mclk_in) begin
        if (valid === 1'b1 && rdy) begin
            chk("word_out", fifo_q.size() > 0 ? fifo_q.pop_front() : 4'hx,
                word);
        end
    end
    initial begin
        repeat (3) @(posedge mclk_in);
        #10 rst_in = 1'b0;
        chk("q_out", 4'h0, q);
        chk("load_ready", 4'h1, {3'h0, ldy});
        $display("test reset done");
        rdy = 1'b1;
        step(1'b1, 4'hf, 1'b0);
        step(1'b0, 4'h0, 1'b0);
        for (i = 0; i < 40; i++) begin
            r = $random(seed);
            rdy = r[8] | r[9];
            step(r[4], r[3:0], 1'b0);
        end
        drain;
        chk("setup_err", 4'h0, {3'h0, serr});
        $display("test random done");
        for (i = 0; i < 4; i++) step(1'b1, {1'b1, exp_q[3:1]}, 1'b0);
        chk("q_out", 4'hf, q);
        $display("test shift_left done");
        step(1'b0, 4'h3, 1'b0);
        step(1'b1, 4'h6, 1'b1);
        chk("order_err", 4'h1, {3'h0, oerr});
        clr = 1'b1;
        @(posedge mclk_in);
        #10 clr = 1'b0;
        chk("order_err", 4'h0, {3'h0, oerr});
        $display("test order done");
        par = 4'h1;
        fbsr_ctl_model_inst.rush();
        exp_q = next_q(1'b0, par);
        if (fifo_q.size() < 16) fifo_q.push_back(exp_q);
        @(posedge mclk_in);
        #10;
        chk("q_out", exp_q, q);
        chk("setup_err", 4'h1, {3'h0, serr});
        chk("order_err", 4'h0, {3'h0, oerr});
        $display("test setup done");
        drain;
        rdy = 1'b0;
        for (i = 0; i < 17; i++) begin
            r = $random(seed);
            step(r[4], r[3:0], 1'b0);
        end
        chk("load_ready", 4'h0, {3'h0, ldy});
        chk("overrun", 4'h1, {3'h0, ovr});
        drain;
        $display("test overrun done");
        summarize;
    end
endmodule // fbsr_core_bench
